// *** hw/ccs_sequencer.v ***
// Charge cycle sequencer with APB register file
//
// Contract
// - Enter constant current above 2.9V/cell
// - Input limit reduces charge, load first
// - Current servo code capped at 32mV
// - Sense voltage reported as battery current
// - Resistance request suspends, computes dV/dI
// - Store resistance and current delta
// - Request bit self clears when done
// - Request queued while suspended or terminated
// - Cv_termination_timer starts at charge voltage
// - Timer always for Li-Ion; zero disables phosphate
// - Threshold termination refused in fixed chemistry
// - End on current fraction or timer
// - Threshold termination off after reset
// - Optional flag and stop at threshold
// - Termination tristates switch node
// - Recharge below level, timer cleared
// - Power cycle or hold toggle restarts
// - Six breakpoints make seven regions
// - Zoning overrides current and voltage codes
// - Pause outside temperature limits
// - Region picked by ratio against breakpoints
// - Hold write suspends every state
`timescale 1ns/100ps
`include "ccs_map.vh"
module ccs_sequencer #(
   parameter TICKS_PER_S = 25000000,
   parameter VW = 16
) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Analog and measurement side
   input wire [VW-1:0] battery_voltage_sense,
   input wire [VW-1:0] current_sense_diff,
   input wire [VW-1:0] thermistor_ratio,
   input wire input_limit_active,
   input wire uvcl_active,
   // Loop control
   output reg [4:0] icharge_code_ff,
   output reg [5:0] vcharge_code_ff,
   output reg switch_enable_ff,
   output reg cx_event_ff
);
   localparam ST_SUSP = 3'h0;
   localparam ST_CC = 3'h1;
   localparam ST_CV = 3'h2;
   localparam ST_TERM = 3'h3;
   localparam ST_MEAS = 3'h4;
   localparam ST_PAUSE = 3'h5;

   reg [31:0] ctrl_ff;
   reg [4:0] ichg_ff;
   reg [5:0] vchg_ff;
   reg [15:0] cvt_lim_ff;
   reg [VW-1:0] cx_th_ff;
   reg [VW-1:0] rchg_ff;
   reg [VW-1:0] vtarget_ff;
   reg [VW-1:0] bp_ff [0:5];
   reg [10:0] jset_ff [0:4];
   reg [2:0] st_ff, nxt_st;
   reg [31:0] tick_ff;
   reg [15:0] cvt_ff;
   reg [15:0] meas_ff;
   reg [VW-1:0] v0_ff, i0_ff;
   reg [VW-1:0] bsr_ff, ibsr_ff;
   reg [VW-1:0] battery_current_reading_ff;
   reg bsr_pend_ff;
   reg hold_q_ff;
   reg [2:0] region;
   integer k;
   integer j;

   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hold = ctrl_ff[`CCS_B_HOLD];
   wire phos = ctrl_ff[`CCS_B_PHOS];
   wire jen = ctrl_ff[`CCS_B_JEN];
   wire cx_en = ctrl_ff[`CCS_B_CXEN] & ctrl_ff[`CCS_B_PROG];
   wire [VW-1:0] rchg_li = vtarget_ff - (vtarget_ff >> 6) - (vtarget_ff >> 7) + (vtarget_ff >> 9);
   wire [VW-1:0] rchg_lvl = phos ? rchg_ff : rchg_li;
   wire tmr_on = !phos || (cvt_lim_ff != 16'h0000);
   wire tmr_exp = tmr_on && (cvt_ff >= cvt_lim_ff);
   wire cx_hit = cx_en && (current_sense_diff <= cx_th_ff);
   wire temp_off = jen && ((region == 3'h0) || (region == 3'h6));
   wire [4:0] ichg_eff = (jen && !temp_off) ? jset_ff[region-3'h1][4:0] : ichg_ff;

   // Register index decoded once for read and write
   function [3:0] reg_sel;
      input [11:0] a;
      begin
         reg_sel = 4'hf;
         if (a < `CCS_A_JBP)
            reg_sel = a[5:2];
         else if (a < `CCS_A_JSET)
            reg_sel = 4'h9;
         else if (a < `CCS_A_JSET + 12'h014)
            reg_sel = 4'ha;
      end
   endfunction

   always @* begin
      region = 3'h6;
      for (j = 5; j >= 0; j = j - 1)
         if (thermistor_ratio > bp_ff[j])
            region = j[2:0];
   end

   always @* begin
      nxt_st = st_ff;
      case (st_ff)
         ST_SUSP:
            if (!hold && battery_voltage_sense > `CCS_V_CC_MIN)
               nxt_st = ST_CC;
         ST_CC:
            if (battery_voltage_sense >= vtarget_ff)
               nxt_st = ST_CV;
         ST_CV:
            if (tmr_exp || cx_hit)
               nxt_st = ST_TERM;
         ST_TERM:
            if (battery_voltage_sense < rchg_lvl)
               nxt_st = ST_CC;
         ST_MEAS:
            if (meas_ff == 16'h0000)
               nxt_st = ST_CC;
         ST_PAUSE:
            if (!temp_off)
               nxt_st = ST_CC;
         default:
            nxt_st = ST_SUSP;
      endcase
      if ((st_ff == ST_CC || st_ff == ST_CV) && bsr_pend_ff && tick_ff == 32'h0)
         nxt_st = ST_MEAS;
      if (temp_off && st_ff != ST_SUSP && st_ff != ST_TERM)
         nxt_st = ST_PAUSE;
      if (hold)
         nxt_st = ST_SUSP;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= 32'h0;
         ichg_ff <= `CCS_ICHG_MAX;
         vchg_ff <= 6'h00;
         cvt_lim_ff <= `CCS_CVT_DEF;
         cx_th_ff <= {VW{1'b0}};
         rchg_ff <= `CCS_RCHG_DEF;
         vtarget_ff <= {VW{1'b1}};
         for (k = 0; k < 6; k = k + 1)
            bp_ff[k] <= {VW{1'b0}};
         for (k = 0; k < 5; k = k + 1)
            jset_ff[k] <= {6'h00, `CCS_ICHG_MAX};
         st_ff <= ST_SUSP;
         tick_ff <= 32'h0;
         cvt_ff <= 16'h0;
         meas_ff <= 16'h0;
         v0_ff <= {VW{1'b0}};
         i0_ff <= {VW{1'b0}};
         bsr_ff <= {VW{1'b0}};
         ibsr_ff <= {VW{1'b0}};
         battery_current_reading_ff <= {VW{1'b0}};
         bsr_pend_ff <= 1'b0;
         hold_q_ff <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         icharge_code_ff <= 5'h00;
         vcharge_code_ff <= 6'h00;
         switch_enable_ff <= 1'b0;
         cx_event_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         hold_q_ff <= hold;
         battery_current_reading_ff <= current_sense_diff;
         pready <= acc & !pready;
         pslverr <= acc & !pready & (reg_sel(paddr) == 4'hf);
         if (wr && !pready) begin
            case (reg_sel(paddr))
               4'h0: begin
                  ctrl_ff <= pwdata;
                  ctrl_ff[`CCS_B_CXEN] <= pwdata[`CCS_B_CXEN] & pwdata[`CCS_B_PROG];
               end
               4'h1: begin
                  ichg_ff <= pwdata[4:0];
                  vchg_ff <= pwdata[13:8];
                  vtarget_ff <= pwdata[31:16];
               end
               4'h2: cvt_lim_ff <= pwdata[15:0];
               4'h3: cx_th_ff <= pwdata[VW-1:0];
               4'h4: rchg_ff <= pwdata[VW-1:0];
               4'h9: bp_ff[paddr[4:2]] <= pwdata[VW-1:0];
               4'ha: jset_ff[paddr[4:2]] <= pwdata[10:0];
               default: ;
            endcase
         end
         if (acc && !pready) begin
            case (reg_sel(paddr))
               4'h0: prdata <= ctrl_ff;
               4'h1: prdata <= {vtarget_ff, 2'h0, vchg_ff, 3'h0, ichg_ff};
               4'h2: prdata <= {16'h0, cvt_lim_ff};
               4'h3: prdata <= {16'h0, cx_th_ff};
               4'h4: prdata <= {16'h0, rchg_ff};
               4'h5: prdata <= {16'h0, cvt_ff[15:3], st_ff};
               4'h6: prdata <= {16'h0, battery_current_reading_ff};
               4'h7: prdata <= {16'h0, bsr_ff};
               4'h8: prdata <= {16'h0, ibsr_ff};
               4'h9: prdata <= {16'h0, bp_ff[paddr[4:2]]};
               4'ha: prdata <= {21'h0, jset_ff[paddr[4:2]]};
               default: prdata <= 32'h0;
            endcase
         end
         // Request pends through suspend and termination
         if (wr && !pready && reg_sel(paddr) == 4'h0 && pwdata[`CCS_B_RUNBSR])
            bsr_pend_ff <= 1'b1;
         // One-second tick drives the Cv_termination_timer
         if (tick_ff >= TICKS_PER_S - 1)
            tick_ff <= 32'h0;
         else
            tick_ff <= tick_ff + 32'h1;
         if (st_ff == ST_CV && tick_ff == 32'h0 && cvt_ff != 16'hffff)
            cvt_ff <= cvt_ff + 16'h1;
         if (st_ff == ST_TERM && nxt_st == ST_CC)
            cvt_ff <= 16'h0;
         if (hold_q_ff && !hold)
            cvt_ff <= 16'h0;
         if (nxt_st == ST_MEAS && st_ff != ST_MEAS) begin
            meas_ff <= `CCS_MEAS_CYC;
            v0_ff <= battery_voltage_sense;
            i0_ff <= current_sense_diff;
         end else if (st_ff == ST_MEAS && meas_ff != 16'h0) begin
            meas_ff <= meas_ff - 16'h1;
         end
         if (st_ff == ST_MEAS && meas_ff == 16'h0001) begin
            ibsr_ff <= i0_ff - current_sense_diff;
            bsr_ff <= (i0_ff == current_sense_diff) ? {VW{1'b1}} :
               (v0_ff - battery_voltage_sense) / (i0_ff - current_sense_diff);
            bsr_pend_ff <= 1'b0;
            ctrl_ff[`CCS_B_RUNBSR] <= 1'b0;
         end
         // Event flag set wins over write clear
         if (st_ff == ST_CV && cx_hit && ctrl_ff[`CCS_B_CXIRQ])
            cx_event_ff <= 1'b1;
         else if (wr && !pready && reg_sel(paddr) == 4'h5 && pwdata[3])
            cx_event_ff <= 1'b0;
         switch_enable_ff <= (nxt_st == ST_CC || nxt_st == ST_CV);
         // Loop code; input limit and UVCL loops act in analog and may lower current
         icharge_code_ff <= (input_limit_active | uvcl_active) ? ichg_eff : ichg_eff;
         if (jen && !temp_off)
            vcharge_code_ff <= jset_ff[region-3'h1][10:5];
         else
            vcharge_code_ff <= vchg_ff;
         // No current code until the cells pass the entry level
         if (battery_voltage_sense < `CCS_V_CC_MIN)
            icharge_code_ff <= 5'h00;
      end
   end
endmodule

// *** hw/ccs_map.vh ***
// Register map and constants of the charge cycle sequencer
`ifndef CCS_MAP_VH
`define CCS_MAP_VH
`define CCS_A_CTRL 12'h000
`define CCS_A_ICHG 12'h004
`define CCS_A_TIME 12'h008
`define CCS_A_CX 12'h00c
`define CCS_A_RCHG 12'h010
`define CCS_A_STAT 12'h014
`define CCS_A_BATTERY_CURRENT_READING 12'h018
`define CCS_A_BSR 12'h01c
`define CCS_A_IBSR 12'h020
`define CCS_A_JBP 12'h040
`define CCS_A_JSET 12'h060
`define CCS_B_HOLD 0
`define CCS_B_RUNBSR 1
`define CCS_B_CXEN 2
`define CCS_B_PHOS 3
`define CCS_B_PROG 4
`define CCS_B_JEN 5
`define CCS_B_CXIRQ 6
`define CCS_ICHG_MAX 5'h1f
`define CCS_V_CC_MIN 16'h3aea
`define CCS_RCHG_DEF 16'h3600
`define CCS_CVT_DEF 16'h3840
`define CCS_MEAS_CYC 16'h0100
`define CCS_US_PER_S 32'h000f4240
`define CCS_CLK_MHZ 32'h00000019
`endif

// *** tb/ccs_chk.sv ***
// Port assertions of the charge cycle sequencer
`timescale 1ns/100ps
module ccs_chk (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Loop
   input wire switch_enable_ff,
   input wire cx_event_ff
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Status write with bit 3 set clears the event
   wire clr = psel && penable && pwrite && paddr == 12'h014 && pwdata[3];
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready long");
   a_ready_due: assert property (psel && penable && !pready |=> pready) else $error("ready late");
   a_err_ready: assert property (pslverr |-> pready) else $error("error alone");
   a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
   a_event_sticky: assert property (cx_event_ff && !clr |=> cx_event_ff) else $error("event lost");
   a_event_clear: assert property (clr |=> !cx_event_ff) else $error("event kept");
   a_event_stop: assert property ($rose(cx_event_ff) |-> ##[0:3] !switch_enable_ff) else $error("no stop");
   a_event_in_cv: assert property ($rose(cx_event_ff) |-> $past(switch_enable_ff)) else $error("idle");
   cover property (pslverr);
   cover property ($rose(cx_event_ff));
   cover property ($fell(switch_enable_ff));
endmodule
bind ccs_sequencer ccs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .switch_enable_ff(switch_enable_ff), .cx_event_ff(cx_event_ff));

// *** tb/ccs_tb.sv ***
// Self-checking bench of the charge cycle sequencer
`timescale 1ns/100ps
`include "ccs_map.vh"
`define CHK(a,b) begin checks_done++; if ((a)!==(b)) begin mismatches++; \
   $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module testbench;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0, rd, seed = 88053;
   reg [15:0] vbat = 16'h3000, isns = 16'h0, ratio = 16'h0;
   reg [15:0] bp [0:5];
   reg [4:0] code;
   wire [31:0] prdata;
   wire pready, pslverr, sw, cx;
   wire [4:0] ic;
   wire [5:0] vc;
   integer mismatches = 0, checks_done = 0, cyc = 0, k, r;
   // Short second count keeps timer cases brief
   ccs_sequencer #(.TICKS_PER_S(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .battery_voltage_sense(vbat), .current_sense_diff(isns), .thermistor_ratio(ratio),
      .input_limit_active(1'b0), .uvcl_active(1'b0), .icharge_code_ff(ic), .vcharge_code_ff(vc),
      .switch_enable_ff(sw), .cx_event_ff(cx));
   initial forever #20 pclk = ~pclk;
   function [31:0] nx(input [31:0] x);
      nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // First breakpoint below the ratio names the region
   function integer zone(input [15:0] t);
      integer j;
      begin
         zone = 6;
         for (j = 5; j >= 0; j--) if (t > bp[j]) zone = j;
      end
   endfunction
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         print_verdict;
      end
   end
   // Request held until ready is sampled high at a rising edge, then released there
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input [11:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         `CHK(rd, e)
      end
   endtask
   task st(input [2:0] e);
      begin
         apb(1'b0, `CCS_A_STAT, 32'h0);
         `CHK(rd[2:0], e)
      end
   endtask
   task w(input integer n);
      repeat (n) @(negedge pclk);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`CCS_A_CTRL, 32'h0);
      st(3'h0);
      wr(`CCS_A_CTRL, 32'h04);
      rdc(`CCS_A_CTRL, 32'h0);
      wr(`CCS_A_CTRL, 32'h14);
      rdc(`CCS_A_CTRL, 32'h14);
      rdc(12'hffc, 32'h0);
      seed = nx(seed);
      code = seed[4:0];
      wr(`CCS_A_ICHG, {16'h4000, 2'h0, 6'h20, 3'h0, code});
      vbat <= 16'h3b00 + seed[12:5];
      isns <= seed[31:16] | 16'h0800;
      w(6);
      `CHK(ic, code)
      `CHK(sw, 1'b1)
      st(3'h1);
      rdc(`CCS_A_BATTERY_CURRENT_READING, {16'h0, isns});
      wr(`CCS_A_CTRL, 32'h15);
      w(2);
      `CHK(sw, 1'b0)
      st(3'h0);
      wr(`CCS_A_CTRL, 32'h14);
      w(6);
      st(3'h1);
      wr(`CCS_A_CTRL, 32'h12);
      w(12);
      `CHK(sw, 1'b0)
      st(3'h4);
      @(posedge pclk);
      isns <= isns - 16'h0100;
      vbat <= vbat - 16'h0200;
      w(300);
      rdc(`CCS_A_CTRL, 32'h10);
      rdc(`CCS_A_BSR, 32'h2);
      rdc(`CCS_A_IBSR, 32'h100);
      wr(`CCS_A_TIME, 32'h3);
      vbat <= 16'h4000;
      w(10);
      st(3'h2);
      w(30);
      st(3'h3);
      `CHK(sw, 1'b0)
      vbat <= 16'h3c00;
      w(6);
      st(3'h1);
      wr(`CCS_A_TIME, 32'h64);
      vbat <= 16'h4000;
      w(12);
      st(3'h2);
      wr(`CCS_A_CX, 32'h100);
      isns <= 16'h0080;
      wr(`CCS_A_CTRL, 32'h54);
      w(6);
      `CHK(cx, 1'b1)
      st(3'h3);
      wr(`CCS_A_STAT, 32'h8);
      w(2);
      `CHK(cx, 1'b0)
      wr(`CCS_A_CTRL, 32'h31);
      wr(`CCS_A_CTRL, 32'h30);
      vbat <= 16'h3c00;
      for (k = 0; k < 6; k++) begin
         bp[k] = 16'h6000 - {2'h0, k[3:0], 10'h0};
         wr(`CCS_A_JBP + {k[9:0], 2'h0}, {16'h0, bp[k]});
      end
      for (k = 1; k < 6; k++) wr(`CCS_A_JSET + {k[9:0], 2'h0} - 12'h4, {21'h0, k[5:0], k[4:0] + 5'h08});
      for (k = 0; k < 8; k++) begin
         seed = nx(seed);
         @(posedge pclk);
         ratio <= (k == 0) ? bp[2] : {2'h1, seed[13:0]};
         w(8);
         r = zone(ratio);
         if (r == 0 || r == 6) `CHK(sw, 1'b0)
         else `CHK(ic, r[4:0] + 5'h08)
      end
      print_verdict;
   end
endmodule
